// ==== usr_susp_resume.sv ====
// Suspend, resume and remote wake-up controller for the device side.
`timescale 1ns/1ps
module usr_susp_resume
    import usr_pkg::*;
#(
    parameter int IDLE_TICKS = IDLE_SUSPEND_US
) (
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RST,
    // Upstream bus lines.
    input wire logic USB_DP,
    input wire logic USB_DM,
    output logic USB_DP_OUT,
    output logic USB_DM_OUT,
    output logic USB_OE_N,
    // Firmware controls.
    input wire logic CPU_POWER_CONTROL_WR,
    input wire logic [7:0] CPU_POWER_CONTROL_WDATA,
    input wire logic VEC_WR,
    input wire logic WAKEUP_REQUEST_BIT,
    input wire logic EXTERNAL_EVENT_ENABLE,
    input wire logic [P3_WIDTH-1:0] P3_MASK,
    // Wake pins.
    input wire logic [P3_WIDTH-1:0] PORT_THREE_INPUTS,
    input wire logic EXTERNAL_EVENT_PIN,
    // Status and interrupt outputs.
    output logic SUSPEND_REQUEST_FLAG,
    output logic RESUME_REQUEST_FLAG,
    output logic IDLE_MODE_FLAG,
    output logic [7:0] INTERRUPT_VECTOR,
    output logic CPU_IRQ,
    output logic EXT_INT0,
    output logic CLOCKS_ENABLE,
    output logic SUSPENDED
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus line synchroniser.
    logic [1:0] bus_raw;
    logic [1:0] bs1_reg;
    logic [1:0] bs2_reg;
    logic [1:0] bs3_reg;
    logic [1:0] bus_reg;
    logic bus_idle;
    logic bus_act;
    assign bus_raw = {USB_DM, USB_DP};
    // Each line passes three flops and changes once the last two agree.
    for (genvar i = 0; i < 2; i++) begin : g_bus
        always_ff @(posedge CLK_SYS) begin
            if (RST) begin
                bs1_reg[i] <= BUS_J[i];
                bs2_reg[i] <= BUS_J[i];
                bs3_reg[i] <= BUS_J[i];
                bus_reg[i] <= BUS_J[i];
            end else begin
                bs1_reg[i] <= bus_raw[i];
                bs2_reg[i] <= bs1_reg[i];
                bs3_reg[i] <= bs2_reg[i];
                if (bs2_reg[i] == bs3_reg[i]) begin
                    bus_reg[i] <= bs3_reg[i];
                end
            end
        end
    end

    logic k_active;
    // Our own K drive must not look like host activity.
    assign bus_idle = (bus_reg == BUS_J) || k_active;
    assign bus_act = !bus_idle;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers: idle timer, wake detector, microsecond tick.
    logic idle_expired;
    usr_wake_if wif ();
    usr_state_e state_reg;
    usr_state_e state_next;
    usr_idle_timer #(
        .TICKS(IDLE_TICKS)
    ) u_idle (
        .clk(CLK_SYS),
        .rst(RST),
        .bus_idle(bus_idle),
        .expired(idle_expired)
    );

    assign wif.p3_pins = PORT_THREE_INPUTS;
    assign wif.ext_pin = EXTERNAL_EVENT_PIN;
    assign wif.p3_mask = P3_MASK;
    assign wif.suspended = (state_reg == ST_SUSPENDED);
    usr_wake_det u_wake (
        .clk(CLK_SYS),
        .rst(RST),
        .w(wif.det)
    );
    logic [7:0] tick_cnt_reg;
    logic tick;
    // Free-running divider giving a one-cycle enable every microsecond.
    always_ff @(posedge CLK_SYS) begin
        if (RST || tick) begin
            tick_cnt_reg <= 8'h00;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 8'h01;
        end
    end

    assign tick = (tick_cnt_reg == 8'(TICK_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////////
    // Power state machine.
    logic idle_flag_reg;
    logic resume_ev;
    logic wake_ff_reg;
    logic int0_wake;
    assign resume_ev = (state_reg == ST_SUSPENDED) && bus_act;
    // Clocks stop only in the suspended state and return on resume or wake.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_ACTIVE: begin
                if (idle_flag_reg) begin
                    state_next = ST_SUSPENDED;
                end else if (idle_expired) begin
                    state_next = ST_FLAGGED;
                end
            end
            ST_FLAGGED: begin
                if (idle_flag_reg) begin
                    state_next = ST_SUSPENDED;
                end else if (bus_act) begin
                    state_next = ST_ACTIVE;
                end
            end
            ST_SUSPENDED: begin
                if (resume_ev || wif.wake_set) begin
                    state_next = ST_RESUMING;
                end
            end
            ST_RESUMING: begin
                if (!idle_flag_reg) begin
                    state_next = ST_ACTIVE;
                end
            end
            default: begin
                state_next = ST_ACTIVE;
            end
        endcase
    end
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state_reg <= ST_ACTIVE;
            CLOCKS_ENABLE <= 1'b1;
            SUSPENDED <= FLAG_RST;
        end else begin
            state_reg <= state_next;
            CLOCKS_ENABLE <= (state_next != ST_SUSPENDED);
            SUSPENDED <= (state_next == ST_SUSPENDED);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Idle flag; the core is only gated, so it resumes after the idle write.
    assign int0_wake = wake_ff_reg && EXTERNAL_EVENT_ENABLE && (state_reg != ST_SUSPENDED);
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            idle_flag_reg <= FLAG_RST;
        end else if (resume_ev || int0_wake) begin
            idle_flag_reg <= 1'b0;
        end else if (CPU_POWER_CONTROL_WR) begin
            idle_flag_reg <= CPU_POWER_CONTROL_WDATA[IDLE_MODE_BIT];
        end
    end

    assign IDLE_MODE_FLAG = idle_flag_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Request flags; a set in the clearing cycle wins.
    logic clr_susp;
    logic clr_res;
    logic clr_ext;
    logic ext_pend_reg;
    assign clr_susp = VEC_WR && INTERRUPT_VECTOR == VEC_SUSPEND;
    assign clr_res = VEC_WR && INTERRUPT_VECTOR == VEC_RESUME;
    assign clr_ext = VEC_WR && INTERRUPT_VECTOR == VEC_EXT_EVENT;
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            SUSPEND_REQUEST_FLAG <= FLAG_RST;
        end else if (idle_expired) begin
            SUSPEND_REQUEST_FLAG <= 1'b1;
        end else if (clr_susp) begin
            SUSPEND_REQUEST_FLAG <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            RESUME_REQUEST_FLAG <= FLAG_RST;
        end else if (resume_ev) begin
            RESUME_REQUEST_FLAG <= 1'b1;
        end else if (clr_res) begin
            RESUME_REQUEST_FLAG <= 1'b0;
        end
    end

    // Wake flop is released only after suspend is left and the event vector is taken.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            wake_ff_reg <= FLAG_RST;
        end else if (wif.wake_set) begin
            wake_ff_reg <= 1'b1;
        end else if (clr_ext && state_reg != ST_SUSPENDED) begin
            wake_ff_reg <= 1'b0;
        end
    end

    // Ordinary event pin falls outside suspend.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ext_pend_reg <= FLAG_RST;
        end else if (wif.ext_fall && EXTERNAL_EVENT_ENABLE) begin
            ext_pend_reg <= 1'b1;
        end else if (clr_ext) begin
            ext_pend_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt vector and request lines.
    logic [7:0] vec_next;
    always_comb begin
        if (SUSPEND_REQUEST_FLAG) begin
            vec_next = VEC_SUSPEND;
        end else if (RESUME_REQUEST_FLAG) begin
            vec_next = VEC_RESUME;
        end else if (EXT_INT0) begin
            vec_next = VEC_EXT_EVENT;
        end else begin
            vec_next = VEC_NONE;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            INTERRUPT_VECTOR <= VEC_NONE;
            EXT_INT0 <= FLAG_RST;
            CPU_IRQ <= FLAG_RST;
        end else begin
            INTERRUPT_VECTOR <= vec_next;
            EXT_INT0 <= (wake_ff_reg || ext_pend_reg) && EXTERNAL_EVENT_ENABLE;
            CPU_IRQ <= SUSPEND_REQUEST_FLAG || RESUME_REQUEST_FLAG || EXT_INT0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Remote wake-up K drive: the request pulse plus a timed tail.
    logic [11:0] k_cnt_reg;
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            k_cnt_reg <= 12'h000;
        end else if (WAKEUP_REQUEST_BIT) begin
            k_cnt_reg <= 12'(K_EXTEND_TICKS);
        end else if (tick && k_cnt_reg != 12'h000) begin
            k_cnt_reg <= k_cnt_reg - 12'h001;
        end
    end

    assign k_active = WAKEUP_REQUEST_BIT || k_cnt_reg != 12'h000;
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            USB_OE_N <= 1'b1;
            USB_DP_OUT <= BUS_J[0];
            USB_DM_OUT <= BUS_J[1];
        end else begin
            USB_OE_N <= !k_active;
            USB_DP_OUT <= k_active ? BUS_K[0] : BUS_J[0];
            USB_DM_OUT <= k_active ? BUS_K[1] : BUS_J[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    susp_flag_set_a: assert property (idle_expired |=> SUSPEND_REQUEST_FLAG ##1 CPU_IRQ)
        else $error("Suspend flag or interrupt missing.");
    susp_flag_clear_a: assert property (clr_susp && !idle_expired |=> !SUSPEND_REQUEST_FLAG)
        else $error("Suspend flag not cleared by vector write.");
    clocks_stop_a: assert property ($rose(idle_flag_reg) && state_reg != ST_SUSPENDED
        && state_reg != ST_RESUMING |=> !CLOCKS_ENABLE)
        else $error("Clocks still running with idle flag set.");
    resume_event_a: assert property (resume_ev |=> RESUME_REQUEST_FLAG && CLOCKS_ENABLE)
        else $error("Resume not flagged or clocks not restarted.");
    resume_idle_a: assert property (resume_ev |=> !IDLE_MODE_FLAG)
        else $error("Resume did not clear the idle flag.");
    resume_clear_a: assert property (clr_res && !resume_ev |=> !RESUME_REQUEST_FLAG)
        else $error("Resume flag not cleared by vector write.");
    k_tail_a: assert property ($fell(WAKEUP_REQUEST_BIT) |-> !USB_OE_N [*8])
        else $error("K drive ended right after the request pulse.");
    k_bound_a: assert property (k_cnt_reg <= 12'(K_EXTEND_TICKS))
        else $error("K tail counter beyond its limit.");
    wake_exit_a: assert property (wif.wake_set && state_reg == ST_SUSPENDED
        |=> CLOCKS_ENABLE && state_reg == ST_RESUMING)
        else $error("Wake did not restart clocks.");
    int0_gate_a: assert property (EXT_INT0 |-> $past(EXTERNAL_EVENT_ENABLE))
        else $error("Event interrupt raised while disabled.");
    wake_vec_a: assert property (EXT_INT0 && !SUSPEND_REQUEST_FLAG && !RESUME_REQUEST_FLAG
        |=> INTERRUPT_VECTOR == VEC_EXT_EVENT)
        else $error("Wake vector not presented.");
    wake_hold_a: assert property (wake_ff_reg && state_reg == ST_SUSPENDED |=> wake_ff_reg)
        else $error("Wake flop cleared inside suspend.");
    cov_suspend: cover property (idle_expired ##[1:20] state_reg == ST_SUSPENDED);
    cov_bus_resume: cover property (resume_ev ##1 RESUME_REQUEST_FLAG);
    cov_pin_wake: cover property (wif.wake_set ##[1:5] EXT_INT0);

endmodule : usr_susp_resume

// ==== usr_pkg.sv ====
// Shared constants and types for the suspend, resume and wake-up block.
package usr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int IDLE_SUSPEND_US = 5000;
    localparam int K_EXTEND_US = 1000;
    localparam int K_EXTEND_TICKS = K_EXTEND_US * 1000 / TICK_NS + 1;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and widths.
    localparam int IDLE_MODE_BIT = 0;
    localparam int P3_WIDTH = 8;
    localparam int P3_EXT_BIT = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt vectors presented to the processor.
    localparam logic [7:0] VEC_NONE = 8'h00;
    localparam logic [7:0] VEC_SUSPEND = 8'h16;
    localparam logic [7:0] VEC_RESUME = 8'h15;
    localparam logic [7:0] VEC_EXT_EVENT = 8'h1f;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and bus line codes, ordered {minus, plus}.
    localparam logic FLAG_RST = 1'b0;
    localparam logic PIN_RST = 1'b1;
    localparam logic [1:0] BUS_J = 2'b01;
    localparam logic [1:0] BUS_K = 2'b10;

    // Power state of the device, Gray coded along the usual path.
    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_FLAGGED = 2'b01,
        ST_SUSPENDED = 2'b11,
        ST_RESUMING = 2'b10
    } usr_state_e;

endpackage : usr_pkg

// ==== usr_wake_if.sv ====
// Signals between the power controller and the local wake detector.
`timescale 1ns/1ps
interface usr_wake_if;
    import usr_pkg::*;
    logic [P3_WIDTH-1:0] p3_pins;
    logic ext_pin;
    logic [P3_WIDTH-1:0] p3_mask;
    logic suspended;
    logic wake_set;
    logic ext_fall;
    modport det (input p3_pins, ext_pin, p3_mask, suspended, output wake_set, ext_fall);
    modport ctl (output p3_pins, ext_pin, p3_mask, suspended, input wake_set, ext_fall);
endinterface : usr_wake_if

// ==== usr_idle_timer.sv ====
// Bus idle timer that signals a suspend condition.
`timescale 1ns/1ps
module usr_idle_timer
    import usr_pkg::*;
#(
    parameter int TICKS = IDLE_SUSPEND_US
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Filtered bus state.
    input wire logic bus_idle,
    // One-cycle pulse after the full idle period.
    output logic expired
);

    logic [7:0] pre_reg;
    logic [15:0] cnt_reg;
    logic tick;

    // Prescaler restarts with any activity so the period is exact.
    always_ff @(posedge clk) begin
        if (rst || !bus_idle) begin
            pre_reg <= 8'h00;
        end else if (tick) begin
            pre_reg <= 8'h00;
        end else begin
            pre_reg <= pre_reg + 8'h01;
        end
    end

    assign tick = (pre_reg == 8'(TICK_CYCLES - 1));

    // Tick count saturates so one idle stretch reports once.
    always_ff @(posedge clk) begin
        if (rst || !bus_idle) begin
            cnt_reg <= 16'h0000;
        end else if (tick && cnt_reg != 16'(TICKS)) begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end

    // Pulse on the tick that completes the period.
    always_ff @(posedge clk) begin
        if (rst) begin
            expired <= FLAG_RST;
        end else begin
            expired <= bus_idle && tick && cnt_reg == 16'(TICKS - 1);
        end
    end

    restart_a: assert property (@(posedge clk) disable iff (rst)
        !bus_idle |=> cnt_reg == 16'h0000 && !expired)
        else $error("Idle count did not restart on activity.");

endmodule : usr_idle_timer

// ==== usr_wake_det.sv ====
// Local wake detector on the port-three and external event pins.
`timescale 1ns/1ps
module usr_wake_det
    import usr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Pins, mask and suspend qualifier.
    usr_wake_if.det w
);

    localparam int NPIN = P3_WIDTH + 1;

    logic [NPIN-1:0] raw;
    logic [NPIN-1:0] s1_reg;
    logic [NPIN-1:0] s2_reg;
    logic [NPIN-1:0] s3_reg;
    logic [NPIN-1:0] filt_reg;
    logic [P3_WIDTH-1:0] gated;
    logic qual;
    logic qual_reg;
    logic ext_prev_reg;

    assign raw = {w.ext_pin, w.p3_pins};

    // Three-stage synchroniser per pin; a level counts once stages two and three agree.
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
        always_ff @(posedge clk) begin
            if (rst) begin
                s1_reg[i] <= PIN_RST;
                s2_reg[i] <= PIN_RST;
                s3_reg[i] <= PIN_RST;
                filt_reg[i] <= PIN_RST;
            end else begin
                s1_reg[i] <= raw[i];
                s2_reg[i] <= s1_reg[i];
                s3_reg[i] <= s2_reg[i];
                if (s2_reg[i] == s3_reg[i]) begin
                    filt_reg[i] <= s3_reg[i];
                end
            end
        end
    end

    // A low, unmasked pin requests wake; the event pin stands in for bit two in suspend.
    for (genvar i = 0; i < P3_WIDTH; i++) begin : g_gate
        if (i == P3_EXT_BIT) begin : g_ext
            assign gated[i] = ~(w.suspended ? filt_reg[P3_WIDTH] : filt_reg[i])
                              & ~w.p3_mask[i];
        end else begin : g_port
            assign gated[i] = ~filt_reg[i] & ~w.p3_mask[i];
        end
    end

    assign qual = (|gated) & w.suspended;

    // Rising edge of the qualified wake term, and normal event pin falls.
    always_ff @(posedge clk) begin
        if (rst) begin
            qual_reg <= FLAG_RST;
            ext_prev_reg <= PIN_RST;
            w.wake_set <= FLAG_RST;
            w.ext_fall <= FLAG_RST;
        end else begin
            qual_reg <= qual;
            ext_prev_reg <= filt_reg[P3_WIDTH];
            w.wake_set <= qual && !qual_reg;
            w.ext_fall <= !w.suspended && ext_prev_reg && !filt_reg[P3_WIDTH];
        end
    end

    wake_qualified_a: assert property (@(posedge clk) disable iff (rst)
        w.wake_set |-> $past(w.suspended) && $past(qual))
        else $error("Wake raised without a qualified pin fall.");

endmodule : usr_wake_det

// ==== usr_host_model.sv ====
// Upstream host model that resolves the two bus lines seen by the device.
`timescale 1ns/1ps
module usr_host_model
    import usr_pkg::*;
(
    // Host command.
    input wire logic send_k,
    // Device drive.
    input wire logic oe_n,
    input wire logic dp_out,
    input wire logic dm_out,
    // Resolved wire level.
    output logic dp,
    output logic dm
);
    ////////////////////////////////////////////////////////////////////////////
    // The device owns the wire while it drives; otherwise host K or pulled-up J.
    always_comb begin
        if (!oe_n) begin
            dp = dp_out;
            dm = dm_out;
        end else begin
            dp = send_k ? BUS_K[0] : BUS_J[0];
            dm = send_k ? BUS_K[1] : BUS_J[1];
        end
    end
endmodule : usr_host_model

// ==== testbench.sv ====
// Self-checking bench for the suspend, resume and wake-up block.
`timescale 1ns/1ps
module testbench;
    import usr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic host_k = 1'b0;
    logic cpu_power_control_wr = 1'b0;
    logic [7:0] cpu_power_control_wdata = 8'h00;
    logic vec_wr = 1'b0;
    logic wup = 1'b0;
    logic ext_en = 1'b0;
    logic [P3_WIDTH-1:0] p3_mask = 8'hff;
    logic [P3_WIDTH-1:0] pins = 8'hff;
    logic ext_pin = 1'b1;
    logic dp, dm, dp_out, dm_out, oe_n, susp_flag, res_flag, idle_flag, irq, int0, clk_en, susp;
    logic [7:0] vec;
    logic [31:0] seed = 32'hccf4ed97;
    int bad_count = 0;
    int compares = 0;

    // Clock at 200 MHz.
    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    usr_susp_resume #(.IDLE_TICKS(5)) uut (
        .CLK_SYS(clk), .RST(rst), .USB_DP(dp), .USB_DM(dm), .USB_DP_OUT(dp_out),
        .USB_DM_OUT(dm_out), .USB_OE_N(oe_n), .CPU_POWER_CONTROL_WR(cpu_power_control_wr), .CPU_POWER_CONTROL_WDATA(cpu_power_control_wdata),
        .VEC_WR(vec_wr), .WAKEUP_REQUEST_BIT(wup), .EXTERNAL_EVENT_ENABLE(ext_en),
        .P3_MASK(p3_mask), .PORT_THREE_INPUTS(pins), .EXTERNAL_EVENT_PIN(ext_pin),
        .SUSPEND_REQUEST_FLAG(susp_flag), .RESUME_REQUEST_FLAG(res_flag),
        .IDLE_MODE_FLAG(idle_flag), .INTERRUPT_VECTOR(vec), .CPU_IRQ(irq),
        .EXT_INT0(int0), .CLOCKS_ENABLE(clk_en), .SUSPENDED(susp));
    usr_host_model host (.send_k(host_k), .oe_n(oe_n), .dp_out(dp_out), .dm_out(dm_out),
        .dp(dp), .dm(dm));

    ////////////////////////////////////////////////////////////////////////////
    // Compare and count; an unknown never matches.
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Print the counts and the verdict, then stop.
    task results;
        $display("Counts: compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    // Next state of the linear feedback shift register.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Step the pseudo-random source.
    task rnd;
        seed = lfsr(seed);
    endtask : rnd

    // Mask with the chosen wake bit open and a random mix elsewhere.
    function automatic logic [7:0] wake_mask(input int b, input logic [7:0] r);
        return r & ~(8'h01 << b);
    endfunction : wake_mask

    // Select a status output to wait on.
    function automatic logic pick(input int s);
        case (s)
            0: return susp_flag;
            1: return res_flag;
            default: return clk_en;
        endcase
    endfunction : pick

    // Bounded wait for a status output to go high.
    task wait_hi(input int s, input int lim, output int n);
        n = 0;
        while (pick(s) !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_hi

    // One-cycle vector write strobe.
    task strobe_vec;
        @(posedge clk);
        vec_wr <= 1'b1;
        @(posedge clk);
        vec_wr <= 1'b0;
        #1;
    endtask : strobe_vec

    // Bus activity, idle span, suspend interrupt, then firmware enters idle.
    task go_suspend(input bit blip);
        int n;
        rnd;
        @(posedge clk);
        host_k <= 1'b1;
        repeat (4 + seed[3:0]) @(posedge clk);
        host_k <= 1'b0;
        if (blip) begin
            repeat (700) @(posedge clk);
            #1;
            chk("early_suspend", 8'h00, susp_flag);
            @(posedge clk);
            host_k <= 1'b1;
            repeat (5) @(posedge clk);
            host_k <= 1'b0;
        end
        wait_hi(0, 1200, n);
        chk("idle_span_ok", 8'h01, 8'(n >= 1000 && n <= 1010));
        @(posedge clk);
        #1;
        chk("suspend_vector", VEC_SUSPEND, vec);
        chk("suspend_irq", 8'h01, irq);
        strobe_vec;
        chk("suspend_flag_clear", 8'h00, susp_flag);
        @(posedge clk);
        cpu_power_control_wr <= 1'b1;
        cpu_power_control_wdata <= seed[15:8] | (8'h01 << IDLE_MODE_BIT);
        @(posedge clk);
        cpu_power_control_wr <= 1'b0;
        #1;
        chk("idle_set", 8'h01, idle_flag);
        repeat (2) @(posedge clk);
        #1;
        chk("clocks_gated", 8'h00, clk_en);
        chk("suspended", 8'h01, susp);
    endtask : go_suspend

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, suspend, bus resume, local wakes, remote wake.
    initial begin
        int n;
        int b;
        logic en;
        logic [7:0] m;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("reset_vector", VEC_NONE, vec);
        chk("reset_clocks", 8'h01, clk_en);
        chk("reset_drive", 8'h01, oe_n);
        go_suspend(1'b1);
        @(posedge clk);
        host_k <= 1'b1;
        wait_hi(1, 10, n);
        chk("resume_flag", 8'h01, res_flag);
        chk("resume_idle_clear", 8'h00, idle_flag);
        chk("resume_clocks", 8'h01, clk_en);
        @(posedge clk);
        #1;
        chk("resume_vector", VEC_RESUME, vec);
        strobe_vec;
        chk("resume_flag_clear", 8'h00, res_flag);
        host_k <= 1'b0;
        for (int r = 0; r < 4; r++) begin
            rnd;
            b = (r == 0) ? P3_EXT_BIT : int'(seed[2:0]);
            en = (r != 3);
            m = wake_mask(b, seed[15:8]);
            @(posedge clk);
            p3_mask <= m;
            ext_en <= en;
            go_suspend(1'b0);
            if (r == 1) begin
                @(posedge clk);
                p3_mask <= 8'hff;
                pins <= 8'h00;
                ext_pin <= 1'b0;
                repeat (20) @(posedge clk);
                #1;
                chk("masked_no_wake", 8'h00, clk_en);
                @(posedge clk);
                pins <= 8'hff;
                ext_pin <= 1'b1;
                repeat (6) @(posedge clk);
                p3_mask <= m;
            end
            @(posedge clk);
            if (b == P3_EXT_BIT) ext_pin <= 1'b0;
            else pins[b] <= 1'b0;
            wait_hi(2, 10, n);
            chk("wake_clocks", 8'h01, clk_en);
            repeat (4) @(posedge clk);
            #1;
            chk("wake_int0", 8'(en), int0);
            chk("wake_idle", 8'(!en), idle_flag);
            if (en) begin
                chk("wake_vector", VEC_EXT_EVENT, vec);
                strobe_vec;
                @(posedge clk);
                #1;
                chk("wake_flop_clear", 8'h00, int0);
            end
            @(posedge clk);
            pins <= 8'hff;
            ext_pin <= 1'b1;
        end
        // A late enable delivers the held wake, then an ordinary event pin fall.
        @(posedge clk);
        ext_en <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("late_wake_idle", 8'h00, idle_flag);
        chk("late_wake_vector", VEC_EXT_EVENT, vec);
        strobe_vec;
        @(posedge clk);
        ext_pin <= 1'b0;
        repeat (10) @(posedge clk);
        #1;
        chk("event_vector", VEC_EXT_EVENT, vec);
        chk("event_idle", 8'h00, idle_flag);
        strobe_vec;
        @(posedge clk);
        #1;
        chk("event_clear", 8'h00, int0);
        @(posedge clk);
        ext_pin <= 1'b1;
        rnd;
        @(posedge clk);
        wup <= 1'b1;
        @(posedge clk);
        #1;
        chk("k_start_drive", 8'h00, oe_n);
        chk("k_on_wire", {6'h00, BUS_K}, {6'h00, dm, dp});
        n = 0;
        repeat (50 + seed[7:0]) begin
            @(posedge clk);
            #1;
            if (oe_n !== 1'b0) n++;
        end
        chk("k_held_pulse", 8'h00, 8'(n));
        @(posedge clk);
        wup <= 1'b0;
        repeat (2000) @(posedge clk);
        #1;
        chk("k_tail", 8'h00, oe_n);
        results;
    end

    // Watchdog far beyond the expected run length.
    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        $display("MISMATCH watchdog expected finish seen timeout");
        results;
    end
endmodule : testbench
